// File: core/valve_stepper_alarm_config.sv
// Valve stepper configuration registers, motion and link-loss alarm handling
`timescale 1ns/100ps
module valve_stepper_alarm_config
  import valve_pkg::*;
#(
  parameter longint REARM_WAIT = REARM_CYCLES
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              link_alive,
  output logic                   step_pulse,
  output logic                   step_dir_open,
  output logic                   valve_fully_open,
  output logic                   link_alarm
);
  localparam logic [31:0] WAIT_LAST = 32'(REARM_WAIT - 1);

  logic [REG_W-1:0]      selector_reg;
  logic [REG_W-1:0]      max_rate_reg;
  logic [REG_W-1:0]      full_open_reg;
  logic [REG_W-1:0]      overtravel_reg;
  logic [REG_W-1:0]      drive_mode_reg;
  logic [REG_W-1:0]      emerg_pos_reg;
  logic [REG_W-1:0]      target_reg;
  logic                  manual_rearm_reg;
  logic                  activate_pulse;
  logic                  close_pulse;
  logic [ADDR_W-1:0]     awaddr_reg;
  logic [REG_W-1:0]      wdata_reg;
  logic [1:0]            wstrb_reg;
  logic                  aw_held;
  logic                  w_held;
  logic                  link_meta;
  logic                  link_sync;
  logic                  link_seen_reg;
  logic                  alarm_reg;
  valve_state_t          state_reg;
  logic [31:0]           wait_reg;
  logic signed [16:0]    pos_reg;
  logic signed [16:0]    goal;
  logic                  half_reg;
  logic                  closing_reg;
  logic                  tick;
  logic [REG_W-1:0]      eff_rate;
  logic [REG_W-1:0]      eff_full;
  logic [REG_W-1:0]      eff_over;
  logic                  moving;
  logic                  at_goal;
  logic                  do_write;
  logic [IDX_W-1:0]      widx;
  logic [REG_W-1:0]      wval;

  // Register index of a byte address
  function automatic logic [IDX_W-1:0] to_idx(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  // True for any index the block answers
  function automatic logic mapped(input logic [IDX_W-1:0] i);
    return (i >= IDX_SELECTOR) && (i <= IDX_STATE);
  endfunction

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old, input logic [REG_W-1:0] d,
                                             input logic [1:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Active parameter set
  assign eff_rate = (selector_reg == RST_ZERO) ? max_rate_reg : PRESET_RATE;
  assign eff_full = (selector_reg == RST_ZERO) ? full_open_reg : PRESET_FULL;
  assign eff_over = (selector_reg == RST_ZERO) ? overtravel_reg : PRESET_OVER;

  // Link level synchroniser, settles while reset is held
  always_ff @(posedge aclk)
  begin
    link_meta <= link_alive;
    link_sync <= link_meta;
  end

  // Write address and data capture, either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign widx     = to_idx(awaddr_reg);
  assign wval     = merge(RST_ZERO, wdata_reg, wstrb_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= RST_ZERO;
      wstrb_reg     <= 2'b00;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held    <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held    <= 1'b1;
        wdata_reg <= s_axi_wdata[REG_W-1:0];
        wstrb_reg <= s_axi_wstrb[1:0];
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(widx) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers, 16-bit words at consecutive indices
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      selector_reg     <= RST_SELECTOR;
      max_rate_reg     <= RST_MAX_RATE;
      full_open_reg    <= RST_FULL_OPEN;
      overtravel_reg   <= RST_OVERTRAVEL;
      drive_mode_reg   <= RST_DRIVE_MODE;
      emerg_pos_reg    <= RST_ZERO;
      target_reg       <= RST_ZERO;
      manual_rearm_reg <= 1'b0;
      activate_pulse   <= 1'b0;
      close_pulse      <= 1'b0;
    end
    else
    begin
      activate_pulse <= 1'b0;
      close_pulse    <= 1'b0;
      if (do_write)
      begin
        case (widx)
          IDX_SELECTOR:   selector_reg   <= merge(selector_reg, wdata_reg, wstrb_reg) & 16'h00ff;
          IDX_MAX_RATE:   max_rate_reg   <= merge(max_rate_reg, wdata_reg, wstrb_reg);
          IDX_FULL_OPEN:  full_open_reg  <= merge(full_open_reg, wdata_reg, wstrb_reg);
          IDX_OVERTRAVEL: overtravel_reg <= merge(overtravel_reg, wdata_reg, wstrb_reg);
          IDX_DRIVE_MODE: drive_mode_reg <= merge(drive_mode_reg, wdata_reg, wstrb_reg);
          IDX_EMERG_POS:  emerg_pos_reg  <= merge(emerg_pos_reg, wdata_reg, wstrb_reg);
          IDX_TARGET:     target_reg     <= merge(target_reg, wdata_reg, wstrb_reg);
          IDX_CONTROL:
          begin
            activate_pulse   <= wval[CTL_ACTIVATE];
            close_pulse      <= wval[CTL_CLOSE];
            manual_rearm_reg <= wstrb_reg[0] ? wval[CTL_MANUAL] : manual_rearm_reg;
          end
          default: ;
        endcase
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(to_idx(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
        case (to_idx(s_axi_araddr))
          IDX_SELECTOR:   s_axi_rdata <= {16'h0000, selector_reg};
          IDX_MAX_RATE:   s_axi_rdata <= {16'h0000, max_rate_reg};
          IDX_FULL_OPEN:  s_axi_rdata <= {16'h0000, full_open_reg};
          IDX_OVERTRAVEL: s_axi_rdata <= {16'h0000, overtravel_reg};
          IDX_RSVD_CUR_A: s_axi_rdata <= {16'h0000, RST_RSVD_CUR_A};
          IDX_RSVD_RES:   s_axi_rdata <= {16'h0000, RST_RSVD_RES};
          IDX_RSVD_CUR_B: s_axi_rdata <= {16'h0000, RST_RSVD_CUR_B};
          IDX_DRIVE_MODE: s_axi_rdata <= {16'h0000, drive_mode_reg};
          IDX_EMERG_POS:  s_axi_rdata <= {16'h0000, emerg_pos_reg};
          IDX_CONTROL:    s_axi_rdata <= {29'h0000_0000, manual_rearm_reg, 2'b00};
          IDX_TARGET:     s_axi_rdata <= {16'h0000, target_reg};
          IDX_POSITION:   s_axi_rdata <= {{15{pos_reg[16]}}, pos_reg};
          IDX_DIAG:       s_axi_rdata <= {16'h0000, alarm_reg, 15'h0000} >> (REG_W - 1 - DIAG_COMM_BIT);
          IDX_STATE:      s_axi_rdata <= {29'h0000_0000, state_reg};
          default:        s_axi_rdata <= '0;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Movement goal for the present state
  always_comb
  begin
    if (state_reg == ST_EMERG)
      goal = (emerg_pos_reg > eff_full) ? $signed({1'b0, eff_full}) : $signed({1'b0, emerg_pos_reg});
    else if (closing_reg)
      goal = -$signed({1'b0, eff_over});
    else if (target_reg > eff_full)
      goal = $signed({1'b0, eff_full});
    else
      goal = $signed({1'b0, target_reg});
    at_goal = (pos_reg == goal) && !half_reg;
    moving  = ((state_reg == ST_RUN) || (state_reg == ST_EMERG)) && !at_goal;
  end

  step_rate_timer u_rate
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rate    (eff_rate),
    .run     (moving),
    .tick    (tick)
  );

  // Alarm and operating state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg     <= ST_IDLE;
      link_seen_reg <= 1'b0;
      alarm_reg     <= 1'b0;
      wait_reg      <= 32'h0000_0000;
    end
    else
    begin
      if (link_sync)
        link_seen_reg <= 1'b1;
      if (link_seen_reg && !link_sync)
        alarm_reg <= 1'b1;
      case (state_reg)
        ST_IDLE:
          if (activate_pulse)
            state_reg <= ST_RUN;
        ST_RUN:
          if (link_seen_reg && !link_sync)
            state_reg <= ST_EMERG;
        ST_EMERG:
          if (at_goal)
            state_reg <= ST_HALT;
        ST_HALT:
        begin
          wait_reg <= 32'h0000_0000;
          if (manual_rearm_reg && activate_pulse && link_sync)
          begin
            alarm_reg <= 1'b0;
            state_reg <= ST_RUN;
          end
          else if (!manual_rearm_reg && link_sync)
            state_reg <= ST_REARM;
        end
        ST_REARM:
        begin
          wait_reg <= wait_reg + 32'h0000_0001;
          if (!link_sync)
            state_reg <= ST_HALT;
          else if (wait_reg >= WAIT_LAST)
          begin
            alarm_reg <= 1'b0;
            state_reg <= ST_RUN;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Position counter in full steps, half-step phase kept aside
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pos_reg          <= '0;
      half_reg         <= 1'b0;
      closing_reg      <= 1'b0;
      step_pulse       <= 1'b0;
      step_dir_open    <= 1'b0;
      valve_fully_open <= 1'b0;
      link_alarm       <= 1'b0;
    end
    else
    begin
      step_pulse       <= 1'b0;
      link_alarm       <= alarm_reg;
      valve_fully_open <= (pos_reg == $signed({1'b0, eff_full})) && !half_reg;
      if (close_pulse && state_reg == ST_RUN)
        closing_reg <= 1'b1;
      else if (closing_reg && at_goal)
      begin
        closing_reg <= 1'b0;
        pos_reg     <= '0;
      end
      if (state_reg != ST_RUN)
        closing_reg <= 1'b0;
      if (tick && moving)
      begin
        step_pulse    <= 1'b1;
        step_dir_open <= (pos_reg < goal) || (pos_reg == goal && half_reg && step_dir_open);
        if (drive_mode_reg == MODE_HALF && !half_reg)
          half_reg <= 1'b1;
        else
        begin
          half_reg <= 1'b0;
          // One full step per completed pair in half-step mode
          if ((pos_reg < goal) || (half_reg && step_dir_open))
            pos_reg <= pos_reg + 17'sd1;
          else
            pos_reg <= pos_reg - 17'sd1;
        end
      end
    end
  end
endmodule

// File: core/valve_pkg.sv
// Register map, reset values and timing constants of the valve stepper block
package valve_pkg;
  localparam int                 ADDR_W          = 16;
  localparam int                 DATA_W          = 32;
  localparam int                 REG_W           = 16;
  localparam int                 IDX_W           = 14;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0]   IDX_SELECTOR    = 14'h3db8;
  localparam logic [IDX_W-1:0]   IDX_MAX_RATE    = 14'h3db9;
  localparam logic [IDX_W-1:0]   IDX_FULL_OPEN   = 14'h3dba;
  localparam logic [IDX_W-1:0]   IDX_OVERTRAVEL  = 14'h3dbb;
  localparam logic [IDX_W-1:0]   IDX_RSVD_CUR_A  = 14'h3dbc;
  localparam logic [IDX_W-1:0]   IDX_RSVD_RES    = 14'h3dbd;
  localparam logic [IDX_W-1:0]   IDX_RSVD_CUR_B  = 14'h3dbe;
  localparam logic [IDX_W-1:0]   IDX_DRIVE_MODE  = 14'h3dbf;
  localparam logic [IDX_W-1:0]   IDX_EMERG_POS   = 14'h3dc0;
  localparam logic [IDX_W-1:0]   IDX_CONTROL     = 14'h3dc1;
  localparam logic [IDX_W-1:0]   IDX_TARGET      = 14'h3dc2;
  localparam logic [IDX_W-1:0]   IDX_POSITION    = 14'h3dc3;
  localparam logic [IDX_W-1:0]   IDX_DIAG        = 14'h3dc4;
  localparam logic [IDX_W-1:0]   IDX_STATE       = 14'h3dc5;
  // Reset values
  localparam logic [REG_W-1:0]   RST_SELECTOR    = 16'h0000;
  localparam logic [REG_W-1:0]   RST_MAX_RATE    = 16'h0028;
  localparam logic [REG_W-1:0]   RST_FULL_OPEN   = 16'h00fa;
  localparam logic [REG_W-1:0]   RST_OVERTRAVEL  = 16'h0000;
  localparam logic [REG_W-1:0]   RST_RSVD_CUR_A  = 16'h0104;
  localparam logic [REG_W-1:0]   RST_RSVD_RES    = 16'h002e;
  localparam logic [REG_W-1:0]   RST_RSVD_CUR_B  = 16'h0000;
  localparam logic [REG_W-1:0]   RST_DRIVE_MODE  = 16'h0001;
  localparam logic [REG_W-1:0]   RST_ZERO        = 16'h0000;
  // Preconfigured valve set used for any non-zero selector (arbitrary values)
  localparam logic [REG_W-1:0]   PRESET_RATE     = 16'h0032;
  localparam logic [REG_W-1:0]   PRESET_FULL     = 16'h01e0;
  localparam logic [REG_W-1:0]   PRESET_OVER     = 16'h0014;
  // Field positions
  localparam int                 DIAG_COMM_BIT   = 14;
  localparam int                 CTL_ACTIVATE    = 0;
  localparam int                 CTL_CLOSE       = 1;
  localparam int                 CTL_MANUAL      = 2;
  localparam logic [REG_W-1:0]   MODE_FULL       = 16'h0000;
  localparam logic [REG_W-1:0]   MODE_HALF       = 16'h0001;
  // AXI responses
  localparam logic [1:0]         RESP_OKAY       = 2'h0;
  localparam logic [1:0]         RESP_SLVERR     = 2'h2;
  // Timing
  localparam longint             CLK_HZ          = 200_000_000;
  localparam longint             REARM_WAIT_S    = 20;
  localparam longint             REARM_CYCLES    = REARM_WAIT_S * CLK_HZ;
  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_EMERG, ST_HALT, ST_REARM} valve_state_t;
endpackage

// File: core/step_rate_timer.sv
// Step tick generator bounded by a steps-per-second rate
`timescale 1ns/100ps
module step_rate_timer
  import valve_pkg::*;
#(
  parameter longint CLK_FREQ = CLK_HZ
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [REG_W-1:0]  rate,
  input  wire logic              run,
  output logic                   tick
);
  localparam logic [31:0] LIMIT = 32'(CLK_FREQ);
  logic [31:0] acc_reg;
  logic [31:0] acc_next;

  // Accumulator overflows at most rate times per second
  always_comb
  begin
    acc_next = acc_reg + {16'h0000, rate};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      acc_reg <= 32'h0000_0000;
      tick    <= 1'b0;
    end
    else if (acc_next >= LIMIT)
    begin
      acc_reg <= acc_next - LIMIT;
      tick    <= 1'b1;
    end
    else
    begin
      acc_reg <= acc_next;
      tick    <= 1'b0;
    end
  end
endmodule

// File: verif/valve_checker.sv
// Assertion checker bound to the valve stepper block
`timescale 1ns/100ps
module valve_checker
  import valve_pkg::*;
#(
  parameter longint REARM_WAIT = REARM_CYCLES
)
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              link_alive,
  input wire logic              step_pulse,
  input wire logic              link_alarm
);
  logic [15:0] gap_reg;
  logic [31:0] alive_reg;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Cycles since last step
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      gap_reg <= 16'hffff;
    else if (step_pulse)
      gap_reg <= 16'h0001;
    else if (gap_reg != 16'hffff)
      gap_reg <= gap_reg + 16'h0001;
  end
  // Cycles the link has been up
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !link_alive)
      alive_reg <= 32'h0000_0000;
    else if (alive_reg != 32'hffff_ffff)
      alive_reg <= alive_reg + 32'h0000_0001;
  end
  sequence link_up_s;
    link_alive [*3];
  endsequence
  sequence link_lost_s;
    !link_alive [*4];
  endsequence
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  w_pulse_a: assert property ($rose(s_axi_wready) |-> ##1 $fell(s_axi_wready))
    else $error("wready held");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("no write response");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  loss_alarm_a: assert property (link_up_s ##1 link_lost_s |=> link_alarm)
    else $error("link loss not flagged");
  alarm_clear_a: assert property ($fell(link_alarm) |-> alive_reg > REARM_WAIT)
    else $error("alarm cleared early");
  step_gap_a: assert property (step_pulse |-> gap_reg >= 16'h0beb)
    else $error("step rate too high");
endmodule
bind valve_stepper_alarm_config valve_checker #(.REARM_WAIT(REARM_WAIT)) valve_checker_inst (.*);

// File: verif/link_master_model.sv
// Master controller and valve model on the far side of the block
`timescale 1ns/100ps
module link_master_model
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               link_on,
  input  wire logic               step_pulse,
  input  wire logic               step_dir_open,
  output logic                    link_alive,
  output logic [15:0]             pulse_cnt,
  output logic signed [15:0]      net_pos
);
  // Link presence as the master sees it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      link_alive <= 1'b0;
    else
      link_alive <= link_on;
  end
  // Valve shaft position in pulses
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pulse_cnt <= 16'h0000;
      net_pos <= 16'sh0000;
    end
    else if (step_pulse)
    begin
      pulse_cnt <= pulse_cnt + 16'h0001;
      net_pos <= step_dir_open ? net_pos + 16'sh0001 : net_pos - 16'sh0001;
    end
  end
endmodule

// File: verif/testbench.sv
// Self-checking bench for the valve stepper block
`timescale 1ns/100ps
module testbench
  import valve_pkg::*;
;
  localparam longint WAIT_C = 50;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'h3;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, link_on = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              link_alive, step_pulse, step_dir_open, valve_fully_open, link_alarm;
  logic [15:0]       pulse_cnt;
  logic signed [15:0] net_pos;
  logic [15:0]       rst_tab [8] = '{16'h0000, 16'h0028, 16'h00fa, 16'h0000,
                                     16'h0104, 16'h002e, 16'h0000, 16'h0001};
  int                failures = 0;
  int                n_tests = 0;
  always #2.5 aclk = ~aclk;
  valve_stepper_alarm_config #(.REARM_WAIT(WAIT_C)) valve_stepper_alarm_config_inst (.*);
  link_master_model link_master_model_inst (.aclk(aclk), .aresetn(aresetn), .link_on(link_on),
    .step_pulse(step_pulse), .step_dir_open(step_dir_open), .link_alive(link_alive),
    .pulse_cnt(pulse_cnt), .net_pos(net_pos));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic hang;
    failures++;
    $display("mismatch at %0t: wait bound used up", $time);
    end_of_test();
  endtask
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] val, input logic [1:0] er);
    bit ok;
    int k;
    ok = 1'b0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, val};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 100 && !ok; k++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      ok = s_axi_bvalid;
    end
    if (!ok)
      hang();
    check(32'(s_axi_bresp), 32'(er), "bresp");
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input logic [1:0] er);
    bit ok;
    int k;
    ok = 1'b0;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 100 && !ok; k++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      ok = s_axi_rvalid;
    end
    if (!ok)
      hang();
    check(32'(s_axi_rresp), 32'(er), "rresp");
    check(s_axi_rdata, exp, "rdata");
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_pulses(input logic [15:0] n);
    int k;
    for (k = 0; k < 30000 && pulse_cnt !== n; k++)
      @(posedge aclk);
    if (pulse_cnt !== n)
      hang();
    repeat (3200) @(posedge aclk);
    check(32'(pulse_cnt), 32'(n), "pulse count");
  endtask
  task automatic wait_alarm(input logic v);
    int k;
    for (k = 0; k < 2000 && link_alarm !== v; k++)
      @(posedge aclk);
    if (link_alarm !== v)
      hang();
    check(32'(link_alarm), 32'(v), "alarm");
  endtask
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    link_on <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(IDX_W'(IDX_SELECTOR + i), 32'(rst_tab[i]), RESP_OKAY);
    wr(IDX_RSVD_RES, 16'h1234, RESP_OKAY);
    rd(IDX_RSVD_RES, 32'h0000_002e, RESP_OKAY);
    wr(14'h0100, 16'h0001, RESP_SLVERR);
    rd(14'h0100, 32'h0000_0000, RESP_SLVERR);
    wr(IDX_SELECTOR, 16'h00ff, RESP_OKAY);
    rd(IDX_SELECTOR, 32'h0000_00ff, RESP_OKAY);
    wr(IDX_SELECTOR, 16'h0000, RESP_OKAY);
    wr(IDX_MAX_RATE, 16'hffff, RESP_OKAY);
    wr(IDX_FULL_OPEN, 16'h0006, RESP_OKAY);
    wr(IDX_OVERTRAVEL, 16'h0002, RESP_OKAY);
    wr(IDX_DRIVE_MODE, MODE_FULL, RESP_OKAY);
    wr(IDX_EMERG_POS, 16'h0002, RESP_OKAY);
    wr(IDX_CONTROL, 16'h0001, RESP_OKAY);
    wr(IDX_TARGET, 16'h0009, RESP_OKAY);
    wait_pulses(16'h0006);
    rd(IDX_POSITION, 32'h0000_0006, RESP_OKAY);
    check(32'(valve_fully_open), 32'h1, "fully open");
    link_on <= 1'b0;
    wait_alarm(1'b1);
    rd(IDX_DIAG, 32'h0000_4000, RESP_OKAY);
    rd(IDX_STATE, 32'h0000_0002, RESP_OKAY);
    wait_pulses(16'h000a);
    check(32'(net_pos), 32'h0000_0002, "emergency position");
    check(32'(valve_fully_open), 32'h0, "not fully open");
    rd(IDX_STATE, 32'h0000_0003, RESP_OKAY);
    link_on <= 1'b1;
    wait_alarm(1'b0);
    rd(IDX_DIAG, 32'h0000_0000, RESP_OKAY);
    wait_pulses(16'h000e);
    rd(IDX_POSITION, 32'h0000_0006, RESP_OKAY);
    wr(IDX_EMERG_POS, 16'h0006, RESP_OKAY);
    wr(IDX_CONTROL, 16'h0004, RESP_OKAY);
    rd(IDX_CONTROL, 32'h0000_0004, RESP_OKAY);
    link_on <= 1'b0;
    wait_alarm(1'b1);
    repeat (20) @(posedge aclk);
    link_on <= 1'b1;
    repeat (3 * WAIT_C) @(posedge aclk);
    check(32'(link_alarm), 32'h1, "manual alarm kept");
    rd(IDX_STATE, 32'h0000_0003, RESP_OKAY);
    wr(IDX_CONTROL, 16'h0005, RESP_OKAY);
    wait_alarm(1'b0);
    wr(IDX_TARGET, 16'h0000, RESP_OKAY);
    wr(IDX_CONTROL, 16'h0002, RESP_OKAY);
    wait_pulses(16'h0016);
    check(32'(net_pos), 32'hffff_fffe, "overtravel");
    rd(IDX_POSITION, 32'h0000_0000, RESP_OKAY);
    wr(IDX_DRIVE_MODE, MODE_HALF, RESP_OKAY);
    wr(IDX_TARGET, 16'h0001, RESP_OKAY);
    wait_pulses(16'h0018);
    rd(IDX_POSITION, 32'h0000_0001, RESP_OKAY);
    end_of_test();
  end
endmodule
